// ### epfifo_pkg.sv
`default_nettype none
package epfifo_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PACKET_LENGTH_OFS = 8'h1c; // Length register
    localparam logic [7:0] DATA_PORT_OFS = 8'h20; // FIFO data port
    localparam logic [15:0] DATA_PORT_RST = 16'h0000; // Port reset value
    localparam logic [15:0] LENGTH_RST = 16'h0000; // Length reset value
    localparam logic [15:0] READ_UNMAPPED = 16'h0000; // Unmapped answer
    // Byte lanes of the data port
    localparam int UPPER_LSB = 8;
    localparam int LOWER_LSB = 0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // One processor bus access, strobes are one-cycle pulses
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // One byte delivered by the USB side for an OUT endpoint
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } host_byte_t;
endpackage
`default_nettype wire

// ### endpoint_fifo_port_length.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Data port is 16 bits, two byte lanes
// - Data port bits writable, cleared on resets
// - Length register holds indexed endpoint byte count
// - Max packet write loads length with size
// - USB bus reset clears the length register
// - Full IN packet validates automatically
// - Short IN packet validates at programmed length
// - Short validation only for programmed transfers
// - OUT acknowledge loads received byte count
// - Odd final byte sits in lower lane
module endpoint_fifo_port_length #(
    parameter int NUM_EP = 16,
    parameter int DEPTH = 1024
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic usb_bus_reset,
    input wire epfifo_pkg::reg_req_t req,
    input wire logic [3:0] ep_index,
    input wire logic ep_is_in,
    input wire logic dma_mode,
    input wire logic validate_endpoint_bit,
    input wire logic max_pkt_wr,
    input wire logic [15:0] max_pkt,
    input wire epfifo_pkg::host_byte_t host_byte,
    input wire logic out_ack,
    output logic [15:0] rdata,
    output logic in_pkt_valid,
    output logic [15:0] in_pkt_len
);
    import epfifo_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Elaboration check on the shape of the buffer; the address wraps
    // by truncation, so the depth must be a power of two
    if (NUM_EP < 1 || NUM_EP > 16 || DEPTH < 2 || DEPTH > 65536 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_shape
        $error("endpoint_fifo_port_length: bad NUM_EP or DEPTH");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] mem [DEPTH]; // Buffer of the indexed endpoint
    logic [15:0] len_q [NUM_EP]; // Byte count per endpoint
    logic [15:0] ptr, next_ptr; // Processor byte pointer
    logic [15:0] hptr, next_hptr; // USB side byte pointer
    logic [15:0] data_word, next_data_word; // Data port contents
    logic [15:0] next_rdata;
    logic next_in_valid;
    logic [15:0] next_in_len;
    logic [3:0] ep_q; // Index seen last cycle
    logic [15:0] len_cur; // Length of the indexed endpoint
    logic [15:0] remain; // Bytes left before the length
    logic [15:0] fill; // Bytes loaded after this write
    logic [7:0] lo_byte, hi_byte;
    logic port_wr, port_rd, len_wr, len_rd, last_odd;
    logic do_validate, short_hit, full_hit;
    logic pkt_done; // No byte of the packet left to read
    logic [15:0] next_len_cur;

    assign len_cur = len_q[ep_index];
    assign lo_byte = mem[ptr[AW-1:0]];
    assign hi_byte = mem[AW'(ptr + 16'd1)];
    assign port_wr = req.wr && req.addr == DATA_PORT_OFS;
    assign port_rd = req.rd && req.addr == DATA_PORT_OFS;
    assign len_wr = req.wr && req.addr == PACKET_LENGTH_OFS;
    assign len_rd = req.rd && req.addr == PACKET_LENGTH_OFS;
    assign remain = len_cur - ptr;
    assign pkt_done = ptr >= len_cur;
    // Last odd byte: only one byte is left in the packet
    assign last_odd = remain == 16'd1;
    assign fill = ptr + (last_odd ? 16'd1 : 16'd2);
    assign full_hit = fill >= max_pkt;
    // Short packet check is off under DMA access
    assign short_hit = !dma_mode && len_cur != 16'h0000 && fill >= len_cur;
    // Validate once the packet size or the programmed count is loaded
    assign do_validate = ep_is_in && port_wr && (full_hit || short_hit);

    // ------------------------------------------------------------
    // Port, pointer and validation next state
    // ------------------------------------------------------------
    // One process decides every next value of the port logic
    always_comb begin
        next_ptr = ptr;
        next_hptr = hptr;
        next_data_word = data_word;
        next_rdata = READ_UNMAPPED;
        next_in_valid = 1'b0;
        next_in_len = in_pkt_len;
        next_len_cur = len_cur;
        if (ep_index != ep_q) begin
            // New endpoint selected: restart at its first byte
            next_ptr = 16'h0000;
        end else if (port_wr) begin
            // Port holds the word last written
            next_data_word = req.wdata;
            next_ptr = fill;
            if (do_validate) begin
                next_in_valid = 1'b1;
                next_in_len = fill;
                next_ptr = 16'h0000;
            end
        end else if (port_rd) begin
            if (pkt_done) begin
                // Nothing left: show the held word, not stale
                // buffer bytes, so a reset port reads back as zero
                next_rdata = data_word;
            end else begin
                // Odd final byte goes out on the lower lane
                if (last_odd) begin
                    next_data_word = {8'h00, lo_byte};
                end else begin
                    // Upper byte at the higher address
                    next_data_word = {hi_byte, lo_byte};
                end
                next_ptr = fill;
                next_rdata = next_data_word;
            end
        end else if (validate_endpoint_bit && ep_is_in) begin
            // Software releases a packet it loaded itself
            next_in_valid = 1'b1;
            next_in_len = ptr;
            next_ptr = 16'h0000;
        end
        if (len_rd) begin
            // Read back the count of the indexed endpoint
            next_rdata = len_cur;
        end
        if (host_byte.valid) begin
            next_hptr = hptr + 16'd1;
        end
        if (len_wr) begin
            // Software may shorten the loaded size
            next_len_cur = req.wdata;
        end
        if (max_pkt_wr) begin
            next_len_cur = max_pkt;
        end
        if (out_ack && !ep_is_in) begin
            // Count of bytes the host really sent
            next_len_cur = hptr;
            next_hptr = 16'h0000;
            next_ptr = 16'h0000;
        end
        if (usb_bus_reset) begin
            // Bus reset clears count, port and pointers
            next_len_cur = LENGTH_RST;
            next_data_word = DATA_PORT_RST;
            next_ptr = 16'h0000;
            next_hptr = 16'h0000;
            next_in_valid = 1'b0;
        end
    end

    // Register stage of the port logic
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr <= 16'h0000;
            hptr <= 16'h0000;
            data_word <= DATA_PORT_RST;
            rdata <= READ_UNMAPPED;
            in_pkt_valid <= 1'b0;
            in_pkt_len <= 16'h0000;
            ep_q <= 4'h0;
        end else begin
            ptr <= next_ptr;
            hptr <= next_hptr;
            data_word <= next_data_word;
            rdata <= next_rdata;
            in_pkt_valid <= next_in_valid;
            in_pkt_len <= next_in_len;
            ep_q <= ep_index;
        end
    end

    // ------------------------------------------------------------
    // Length table and buffer memory
    // ------------------------------------------------------------
    // Outside the resets only the indexed entry changes; others keep their count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_EP; i++) begin
                len_q[i] <= LENGTH_RST;
            end
        end else if (usb_bus_reset) begin
            for (int i = 0; i < NUM_EP; i++) begin
                len_q[i] <= LENGTH_RST;
            end
        end else begin
            len_q[ep_index] <= next_len_cur;
        end
    end

    // Buffer has no reset; contents are defined by the writes
    always_ff @(posedge ref_clk) begin
        if (port_wr && ep_index == ep_q) begin
            mem[ptr[AW-1:0]] <= req.wdata[LOWER_LSB +: 8];
            if (!last_odd) begin
                mem[AW'(ptr + 16'd1)] <= req.wdata[UPPER_LSB +: 8];
            end
        end
        if (host_byte.valid) begin
            mem[hptr[AW-1:0]] <= host_byte.data;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [15:0] len_any;
    assign len_any = len_q[0];

    bus_reset_clear_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        usb_bus_reset |=> len_any == 16'h0000 && data_word == 16'h0000)
        else $error("bus reset did not clear length and port");

    port_write_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        port_wr && ep_index == ep_q && !usb_bus_reset
        |=> data_word == $past(req.wdata))
        else $error("data port lost the written word");

    size_load_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        max_pkt_wr && !usb_bus_reset && !out_ack && $stable(ep_index)
        ##1 $stable(ep_index) |-> len_cur == $past(max_pkt))
        else $error("length not loaded with packet size");

    length_read_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        len_rd && !port_rd |=> rdata == $past(len_cur))
        else $error("length read returned wrong count");

    auto_valid_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        do_validate && ep_index == ep_q && !usb_bus_reset
        |=> in_pkt_valid && in_pkt_len == $past(fill) && ptr == 16'h0000)
        else $error("packet not validated when loaded");

    dma_short_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        in_pkt_valid && $past(dma_mode) && $past(port_wr)
        |-> in_pkt_len >= $past(max_pkt))
        else $error("short packet validated under dma");

    out_count_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        out_ack && !ep_is_in && !usb_bus_reset && !max_pkt_wr
        ##1 $stable(ep_index) |-> len_cur == $past(hptr))
        else $error("out count not loaded on acknowledge");

    odd_lane_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        port_rd && last_odd && ep_index == ep_q && !usb_bus_reset
        |=> rdata == {8'h00, $past(lo_byte)})
        else $error("odd last byte not on lower lane");

    ptr_step_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        port_rd && !last_odd && !pkt_done && ep_index == ep_q
        && !usb_bus_reset && !out_ack |=> ptr == $past(ptr) + 16'd2)
        else $error("pointer did not advance two bytes");
endmodule
`default_nettype wire

// ### cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Processor on the parallel register bus
// ------------------------------------------------------------
module cpu_model (
    input wire logic ref_clk,
    input wire logic [15:0] rdata,
    output var epfifo_pkg::reg_req_t req
);
    import epfifo_pkg::*;

    // Bus idle from time zero
    initial req = '0;

    // One strobe cycle, then the edge that returns read data
    task automatic access(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(posedge ref_clk);
        #1;
        req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        // Strobe dropped only after the taking edge
        req = '0;
        q = rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import epfifo_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic usb_bus_reset = 1'b0;
    logic [3:0] ep_index = 4'h0; // Indexed endpoint
    logic ep_is_in = 1'b0;
    logic dma_mode = 1'b0;
    logic validate_endpoint_bit = 1'b0;
    logic max_pkt_wr = 1'b0;
    logic [15:0] max_pkt = 16'h0000;
    host_byte_t host_byte = '0;
    logic out_ack = 1'b0;
    reg_req_t req;
    logic [15:0] rdata, in_pkt_len;
    logic in_pkt_valid;
    int n_fail = 0, total_checks = 0, n_valid = 0;
    logic [31:0] seed = 32'h0000_0027; // Fixed seed, repeatable run
    logic [7:0] b [5];

    always #2.5 ref_clk = ~ref_clk;

    endpoint_fifo_port_length dut (.ref_clk(ref_clk), .rst(rst),
        .usb_bus_reset(usb_bus_reset), .req(req), .ep_index(ep_index),
        .ep_is_in(ep_is_in), .dma_mode(dma_mode),
        .validate_endpoint_bit(validate_endpoint_bit),
        .max_pkt_wr(max_pkt_wr), .max_pkt(max_pkt),
        .host_byte(host_byte), .out_ack(out_ack), .rdata(rdata),
        .in_pkt_valid(in_pkt_valid), .in_pkt_len(in_pkt_len));
    cpu_model cpu (.ref_clk(ref_clk), .rdata(rdata), .req(req));

    // Count release pulses; length holds, so it is read later
    always @(posedge ref_clk) if (in_pkt_valid === 1'b1) n_valid++;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        cpu.access(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        cpu.access(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask

    // Pulse lands one edge after the cause, sampled one edge later
    task automatic vchk(input int n, input logic [15:0] len);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(16'(n_valid), 16'(n));
        chk(in_pkt_len, len);
    endtask

    task automatic busrst;
        @(posedge ref_clk);
        #1 usb_bus_reset = 1'b1;
        @(posedge ref_clk);
        #1 usb_bus_reset = 1'b0;
    endtask

    task automatic conclude;
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog far beyond the ninety or so cycles needed
    initial begin
        #20000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst = 1'b0;
        rc(PACKET_LENGTH_OFS, 16'h0000);
        rc(DATA_PORT_OFS, 16'h0000);
        rc(8'h40, 16'h0000);
        busrst();
        $display("test reset done");
        @(posedge ref_clk);
        #1 max_pkt = 16'h0008;
        max_pkt_wr = 1'b1;
        @(posedge ref_clk);
        #1 max_pkt_wr = 1'b0;
        ep_is_in = 1'b1;
        rc(PACKET_LENGTH_OFS, 16'h0008);
        wr(PACKET_LENGTH_OFS, 16'h0003);
        rc(PACKET_LENGTH_OFS, 16'h0003);
        wr(DATA_PORT_OFS, 16'h2211);
        wr(DATA_PORT_OFS, 16'h0033);
        vchk(1, 16'h0003);
        $display("test short in done");
        wr(PACKET_LENGTH_OFS, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(DATA_PORT_OFS, seed[15:0]);
        end
        vchk(2, 16'h0008);
        $display("test full in done");
        dma_mode = 1'b1;
        wr(PACKET_LENGTH_OFS, 16'h0002);
        seed = xs(seed);
        wr(DATA_PORT_OFS, seed[15:0]);
        vchk(2, 16'h0008);
        @(posedge ref_clk);
        #1 validate_endpoint_bit = 1'b1;
        @(posedge ref_clk);
        #1 validate_endpoint_bit = 1'b0;
        dma_mode = 1'b0;
        vchk(3, 16'h0002);
        $display("test dma done");
        ep_is_in = 1'b0;
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            b[i] = seed[7:0];
            @(posedge ref_clk);
            #1 host_byte = '{valid: 1'b1, data: b[i]};
        end
        @(posedge ref_clk);
        #1 host_byte = '0;
        out_ack = 1'b1;
        @(posedge ref_clk);
        #1 out_ack = 1'b0;
        rc(PACKET_LENGTH_OFS, 16'h0005);
        rc(DATA_PORT_OFS, {b[1], b[0]});
        rc(DATA_PORT_OFS, {b[3], b[2]});
        rc(DATA_PORT_OFS, {8'h00, b[4]});
        // Another endpoint keeps its own count
        ep_index = 4'h1;
        rc(PACKET_LENGTH_OFS, 16'h0000);
        ep_index = 4'h0;
        rc(PACKET_LENGTH_OFS, 16'h0005);
        $display("test out done");
        busrst();
        rc(PACKET_LENGTH_OFS, 16'h0000);
        rc(DATA_PORT_OFS, 16'h0000);
        $display("test bus reset done");
        conclude();
    end
endmodule
`default_nettype wire
